// *** logic/power_mode_controller.sv ***
// Behaviour
// R1: Main regulator in run, sleep, stop0
// R2: Low-power regulator in low-power and stop1/2
// R3: Standby retention keeps low-power regulator on
// R4: Shutdown, and standby without retention, power both regulators down
// R5: Range 1 allows 80 MHz processor clock
// R6: Range 2 limits all clocks to 26 MHz
// R7: Low-power regulator alone means low-power run
// R8: Low-power run: cpu 2 MHz, peripherals 16 MHz
// R9: Brownout holds reset except in shutdown
// R10: Threshold detector flags falling/rising crossings
// R11: Report peripheral supplies within functional range
// R12: Provide sleep, low-power, stop, standby, shutdown
// R13: Sleep modes wake on interrupt within 6 cycles
// R14: Low-power modes forbid PLL, USB, random generator
// R15: Stop modes: flash off, slow clocks, freeze
// R16: Standby/shutdown power off peripherals, hold I/O
// R17: Standby/shutdown wake only from allowed sources
// R18: Flash may power down when running from SRAM
// R19: Each peripheral clock gated independently
// R20: Start in run mode after reset
// R21: Low-power sleep only from, back to, low-power run
// R22: Sleep stops only the processor clock
// R23: Mode register changes on request or wake
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int NUM_PERIPH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enter_req,
  input wire pmode_t enter_mode,
  input wire logic vrange2_sel,
  input wire logic retention_en,
  input wire logic irq_event,
  input wire logic stop_wake_event,
  input wire logic independent_watchdog_event,
  input wire logic rtc_event,
  input wire logic exec_from_sram,
  input wire logic flash_pd_req,
  input wire logic [7:0] cpu_clk_req_mhz,
  input wire logic pvd_en,
  input wire logic pvd_on_fall,
  input wire logic pvd_on_rise,
  input wire logic [1:0] io_pull_sel,
  input wire logic [NUM_PERIPH-1:0] periph_clk_req,
  input wire logic [NUM_PERIPH-1:0] stop01_allow,
  input wire logic [NUM_PERIPH-1:0] stop2_allow,
  input wire logic [NUM_PERIPH-1:0] standby_allow,
  input wire logic reset_pin_n,
  input wire logic [NUM_WAKE_PINS-1:0] wakeup_pin,
  input wire logic supply_below_bor,
  input wire logic supply_below_pvd,
  input wire logic [2:0] pvm_low,
  output pmode_t mode,
  output regulator_ctl_t regulator,
  output clock_ctl_t clocks,
  output io_ctl_t io,
  output logic [7:0] cpu_max_mhz,
  output logic [7:0] periph_max_mhz,
  output logic clk_over_limit,
  output logic bor_reset,
  output logic pvd_event,
  output logic [2:0] pvm_ok,
  output logic [NUM_PERIPH-1:0] periph_clk_en,
  output logic [NUM_PERIPH-1:0] periph_frozen,
  output logic [NUM_PERIPH-1:0] periph_pwr_off
);

  // ----------------------------------------------------------------
  // Pin synchronisers with agreement filter
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] filt_r;
  logic [NSYNC-1:0] filt_d_r;

  assign pins = {pvm_low, supply_below_pvd, supply_below_bor, wakeup_pin, reset_pin_n};

  // Three stages; filtered value moves once stages two and three agree
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        s1_r[i] <= SYNC_RST_VAL[i];
        s2_r[i] <= SYNC_RST_VAL[i];
        s3_r[i] <= SYNC_RST_VAL[i];
        filt_r[i] <= SYNC_RST_VAL[i];
        filt_d_r[i] <= SYNC_RST_VAL[i];
      end else begin
        s1_r[i] <= pins[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
        filt_d_r[i] <= filt_r[i];
      end
    end
  end

  // Decoded pin events
  logic nrst_low;
  logic bor_low;
  logic wake_pin_edge;
  logic pvd_fell;
  logic pvd_rose;
  assign nrst_low = ~filt_r[SYN_NRST];
  assign bor_low = filt_r[SYN_BOR];
  assign wake_pin_edge = |(filt_r[SYN_WAKE_LO +: NUM_WAKE_PINS] &
                           ~filt_d_r[SYN_WAKE_LO +: NUM_WAKE_PINS]);
  assign pvd_fell = filt_r[SYN_PVD] & ~filt_d_r[SYN_PVD];
  assign pvd_rose = ~filt_r[SYN_PVD] & filt_d_r[SYN_PVD];

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  pmode_t mode_r;
  pmode_t mode_nxt;
  logic run_entry_ok;
  logic lp_entry_ok;
  logic force_run;

  // Legal entry targets from each software-running mode
  assign run_entry_ok = enter_req && (enter_mode inside
    {PM_SLEEP, PM_LP_RUN, PM_STOP0, PM_STOP1, PM_STOP2, PM_STANDBY, PM_SHUTDOWN});
  assign lp_entry_ok = enter_req && (enter_mode inside
    {PM_RUN, PM_LP_SLEEP, PM_STOP1, PM_STOP2, PM_STANDBY, PM_SHUTDOWN}); // R21
  // Reset pin anywhere, brownout anywhere but shutdown
  assign force_run = nrst_low || (bor_low && mode_r != PM_SHUTDOWN); // R9 R17

  // Next mode
  always_comb begin
    mode_nxt = mode_r; // R23
    if (force_run) begin
      mode_nxt = PM_RUN;
    end else begin
      case (mode_r)
        PM_RUN: begin
          if (run_entry_ok) mode_nxt = enter_mode; // R12
        end
        PM_SLEEP: begin
          if (irq_event) mode_nxt = PM_RUN; // R13 R22
        end
        PM_LP_RUN: begin
          if (lp_entry_ok) mode_nxt = enter_mode; // R7
        end
        PM_LP_SLEEP: begin
          if (irq_event) mode_nxt = PM_LP_RUN; // R13 R21
        end
        PM_STOP0, PM_STOP1, PM_STOP2: begin
          if (stop_wake_event) mode_nxt = PM_RUN;
        end
        PM_STANDBY: begin
          if (wake_pin_edge || rtc_event || independent_watchdog_event) mode_nxt = PM_RUN; // R17
        end
        PM_SHUTDOWN: begin
          if (wake_pin_edge || rtc_event) mode_nxt = PM_RUN; // R17
        end
        default: mode_nxt = PM_RUN;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= PM_RUN; // R20
    end else begin
      mode_r <= mode_nxt; // R23
    end
  end

  assign mode = mode_r;

  // ----------------------------------------------------------------
  // Mode decode for the next cycle
  // ----------------------------------------------------------------
  logic nx_active;
  logic nx_lp;
  logic nx_stop;
  logic nx_off;
  logic nx_ret;
  regulator_ctl_t reg_nxt;
  clock_ctl_t clk_nxt;
  io_ctl_t io_nxt;
  logic [7:0] cpu_max_nxt;
  logic [7:0] periph_max_nxt;
  logic [NUM_PERIPH-1:0] allow_nxt;

  assign nx_active = mode_nxt inside {PM_RUN, PM_SLEEP, PM_LP_RUN, PM_LP_SLEEP};
  assign nx_lp = mode_nxt inside {PM_LP_RUN, PM_LP_SLEEP};
  assign nx_stop = mode_nxt inside {PM_STOP0, PM_STOP1, PM_STOP2};
  assign nx_off = mode_nxt inside {PM_STANDBY, PM_SHUTDOWN};
  assign nx_ret = (mode_nxt == PM_STANDBY) && retention_en;

  // Regulator selection
  assign reg_nxt.main_on = mode_nxt inside {PM_RUN, PM_SLEEP, PM_STOP0}; // R1 R4
  assign reg_nxt.lp_on = nx_lp || (mode_nxt inside {PM_STOP1, PM_STOP2}) || nx_ret; // R2 R3 R4
  assign reg_nxt.ret_only = nx_ret; // R3

  // Clock and memory gating
  assign clk_nxt.cpu_en = mode_nxt inside {PM_RUN, PM_LP_RUN}; // R22
  assign clk_nxt.flash_on = nx_active && !(flash_pd_req && exec_from_sram); // R15 R18
  assign clk_nxt.fast_osc_en = nx_active; // R15
  assign clk_nxt.slow_clk_en = mode_nxt != PM_SHUTDOWN; // R15
  assign clk_nxt.pll_allowed = mode_nxt inside {PM_RUN, PM_SLEEP}; // R14
  assign clk_nxt.usb_rng_en = mode_nxt inside {PM_RUN, PM_SLEEP}; // R14

  // Frequency ceilings
  assign cpu_max_nxt = nx_lp ? CPU_MAX_LP_MHZ :
                       (vrange2_sel ? CLK_MAX_RANGE2_MHZ : CPU_MAX_RANGE1_MHZ); // R5 R6 R8
  assign periph_max_nxt = nx_lp ? PERIPH_MAX_LP_MHZ :
                          (vrange2_sel ? CLK_MAX_RANGE2_MHZ : CPU_MAX_RANGE1_MHZ); // R6 R8

  // I/O hold state in the unpowered modes
  assign io_nxt.hold_en = nx_off; // R16
  assign io_nxt.pull = nx_off ? io_pull_sel : IO_FLOAT; // R16

  // Peripherals allowed to keep running in the current deep mode
  assign allow_nxt = (mode_nxt inside {PM_STOP0, PM_STOP1}) ? stop01_allow :
                     (mode_nxt == PM_STOP2) ? stop2_allow :
                     (mode_nxt == PM_STANDBY) ? standby_allow : '0;

  // ----------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regulator <= '{main_on: 1'b1, lp_on: 1'b0, ret_only: 1'b0};
      clocks <= '{cpu_en: 1'b1, flash_on: 1'b1, fast_osc_en: 1'b1, slow_clk_en: 1'b1,
                  pll_allowed: 1'b1, usb_rng_en: 1'b1};
      io <= '{hold_en: 1'b0, pull: IO_FLOAT};
      cpu_max_mhz <= CPU_MAX_RANGE1_MHZ;
      periph_max_mhz <= CPU_MAX_RANGE1_MHZ;
    end else begin
      regulator <= reg_nxt;
      clocks <= clk_nxt;
      io <= io_nxt;
      cpu_max_mhz <= cpu_max_nxt;
      periph_max_mhz <= periph_max_nxt;
    end
  end

  // Per-peripheral gating, freeze and power-off
  for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_periph
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        periph_clk_en[p] <= 1'b0;
        periph_frozen[p] <= 1'b0;
        periph_pwr_off[p] <= 1'b0;
      end else begin
        periph_frozen[p] <= nx_stop && !allow_nxt[p]; // R15
        periph_pwr_off[p] <= nx_off && !allow_nxt[p]; // R16
        periph_clk_en[p] <= periph_clk_req[p] && (nx_active || allow_nxt[p]); // R19
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervisors
  // ----------------------------------------------------------------
  logic pvd_live;
  assign pvd_live = pvd_en && !(mode_r inside {PM_STANDBY, PM_SHUTDOWN});

  // Brownout hold, detector crossing pulse, clock ceiling check
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bor_reset <= 1'b0;
      pvd_event <= 1'b0;
      clk_over_limit <= 1'b0;
    end else begin
      bor_reset <= bor_low && (mode_r != PM_SHUTDOWN); // R9
      pvd_event <= pvd_live && ((pvd_fell && pvd_on_fall) || (pvd_rose && pvd_on_rise)); // R10
      clk_over_limit <= clk_nxt.cpu_en && (cpu_clk_req_mhz > cpu_max_nxt); // R5 R6 R8
    end
  end

  // Supply in range when its monitor is not low
  assign pvm_ok = ~filt_r[SYN_PVM_LO +: 3]; // R11

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_main_reg;
    (mode inside {PM_RUN, PM_SLEEP, PM_STOP0}) |-> regulator.main_on && !regulator.lp_on;
  endproperty
  a_main_reg: assert property (p_main_reg) else $error("main regulator not selected"); // R1

  property p_lp_reg;
    (mode inside {PM_LP_RUN, PM_LP_SLEEP, PM_STOP1, PM_STOP2}) |->
      regulator.lp_on && !regulator.main_on;
  endproperty
  a_lp_reg: assert property (p_lp_reg) else $error("low-power regulator not selected"); // R2

  property p_retention;
    (mode == PM_STANDBY) |-> regulator.ret_only == $past(retention_en) &&
      regulator.lp_on == $past(retention_en) && !regulator.main_on;
  endproperty
  a_retention: assert property (p_retention) else $error("standby retention wrong"); // R3

  property p_off_regs;
    (mode == PM_SHUTDOWN) |-> !regulator.main_on && !regulator.lp_on && io.hold_en;
  endproperty
  a_off_regs: assert property (p_off_regs) else $error("regulators on in shutdown"); // R4

  property p_range_limits;
    (mode == PM_RUN) |-> cpu_max_mhz == ($past(vrange2_sel) ? 8'h1a : 8'h50) &&
      periph_max_mhz == ($past(vrange2_sel) ? 8'h1a : 8'h50);
  endproperty
  a_range_limits: assert property (p_range_limits) else $error("range limit wrong"); // R5

  property p_lp_limit;
    (mode == PM_LP_RUN) |-> cpu_max_mhz == 8'h02 && periph_max_mhz == 8'h10 &&
      !clocks.pll_allowed && !clocks.usb_rng_en;
  endproperty
  a_lp_limit: assert property (p_lp_limit) else $error("low-power run limits wrong"); // R8

  property p_bor;
    (bor_low && mode != PM_SHUTDOWN) |=> bor_reset && mode == PM_RUN;
  endproperty
  a_bor: assert property (p_bor) else $error("brownout did not hold reset"); // R9

  property p_sleep_wake;
    (mode == PM_SLEEP && irq_event && !force_run) |-> ##[1:6] clocks.cpu_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake too slow"); // R13

  property p_lp_sleep_entry;
    (mode == PM_LP_SLEEP && $past(mode) != PM_LP_SLEEP) |-> $past(mode) == PM_LP_RUN;
  endproperty
  a_lp_sleep_entry: assert property (p_lp_sleep_entry) else $error("bad sleep entry"); // R21

  property p_shutdown_exit;
    ($past(mode) == PM_SHUTDOWN && mode != PM_SHUTDOWN) |->
      $past(wake_pin_edge || rtc_event || nrst_low);
  endproperty
  a_shutdown_exit: assert property (p_shutdown_exit) else $error("illegal wake"); // R17

  property p_stop_freeze;
    (mode inside {PM_STOP0, PM_STOP1, PM_STOP2}) |-> !clocks.flash_on &&
      !clocks.fast_osc_en && clocks.slow_clk_en && !clocks.cpu_en;
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("stop clocks wrong"); // R15

  c_sleep_wake: cover property (mode == PM_SLEEP ##1 mode == PM_RUN);
  c_lp_sleep: cover property (mode == PM_LP_SLEEP ##1 mode == PM_LP_RUN);
  c_standby_wake: cover property (mode == PM_STANDBY ##1 mode == PM_RUN);
  c_brownout: cover property (bor_reset);

endmodule

// *** logic/power_mode_pkg.sv ***
package power_mode_pkg;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PM_RUN      = 4'h0,
    PM_SLEEP    = 4'h1,
    PM_LP_RUN   = 4'h2,
    PM_LP_SLEEP = 4'h3,
    PM_STOP0    = 4'h4,
    PM_STOP1    = 4'h5,
    PM_STOP2    = 4'h6,
    PM_STANDBY  = 4'h7,
    PM_SHUTDOWN = 4'h8
  } pmode_t;

  // ----------------------------------------------------------------
  // Clock limits in MHz
  // ----------------------------------------------------------------
  localparam logic [7:0] CPU_MAX_RANGE1_MHZ = 8'h50;  // 80 MHz
  localparam logic [7:0] CLK_MAX_RANGE2_MHZ = 8'h1a;  // 26 MHz
  localparam logic [7:0] CPU_MAX_LP_MHZ = 8'h02;      // 2 MHz
  localparam logic [7:0] PERIPH_MAX_LP_MHZ = 8'h10;   // 16 MHz fast oscillator

  // Sleep wake latency bound in clock cycles
  localparam int SLEEP_WAKE_MAX_CYCLES = 6;

  // ----------------------------------------------------------------
  // Pin synchroniser layout and idle values
  // ----------------------------------------------------------------
  localparam int NUM_WAKE_PINS = 5;
  localparam int SYN_NRST = 0;
  localparam int SYN_WAKE_LO = 1;
  localparam int SYN_BOR = 6;
  localparam int SYN_PVD = 7;
  localparam int SYN_PVM_LO = 8;
  localparam int NSYNC = 11;
  localparam logic [NSYNC-1:0] SYNC_RST_VAL = 11'h001;

  // I/O state encodings for standby and shutdown
  localparam logic [1:0] IO_FLOAT = 2'h0;
  localparam logic [1:0] IO_PULLUP = 2'h1;
  localparam logic [1:0] IO_PULLDOWN = 2'h2;

  // ----------------------------------------------------------------
  // Grouped control outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic main_on;
    logic lp_on;
    logic ret_only;
  } regulator_ctl_t;

  typedef struct packed {
    logic cpu_en;
    logic flash_on;
    logic fast_osc_en;
    logic slow_clk_en;
    logic pll_allowed;
    logic usb_rng_en;
  } clock_ctl_t;

  typedef struct packed {
    logic hold_en;
    logic [1:0] pull;
  } io_ctl_t;

endpackage

// *** tb/power_far_side.sv ***
module power_far_side
  import power_mode_pkg::*;
(
  input wire logic ref_clk,
  output logic reset_pin_n,
  output logic [NUM_WAKE_PINS-1:0] wakeup_pin,
  output logic below_brownout,
  output logic below_detector,
  output logic [2:0] periph_supply_low,
  output logic [3:0] evt
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels: pins released, supplies in range
  initial begin
    reset_pin_n = 1'b1;
    wakeup_pin = '0;
    below_brownout = 1'b0;
    below_detector = 1'b0;
    periph_supply_low = 3'h0;
    evt = 4'h0;
  end

  // One-cycle event: 0 interrupt, 1 stop wake, 2 watchdog, 3 clock alarm
  task automatic pulse(input int k);
    evt[k] = 1'b1;
    @(negedge ref_clk);
    evt[k] = 1'b0;
    @(negedge ref_clk);
  endtask

  // Asynchronous pin held past the filter; index 5 is the reset pin
  task automatic pin(input int k);
    if (k < NUM_WAKE_PINS) wakeup_pin[k] = 1'b1;
    else reset_pin_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    wakeup_pin = '0;
    reset_pin_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask

  // Comparator levels, held long enough to cross the synchroniser
  task automatic supply(input logic b, input logic p, input logic [2:0] v);
    below_brownout = b;
    below_detector = p;
    periph_supply_low = v;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

// *** tb/tb_power_mode_controller.sv ***
module tb_power_mode_controller import power_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    pmode_t m;
    regulator_ctl_t r;
    clock_ctl_t c;
    logic [7:0] cmax;
    logic [7:0] pmax;
    logic ovr;
    logic bor;
    logic [7:0] en;
    logic [7:0] fr;
    logic [7:0] po;
  } snap_t;

  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn, enter_req, vrange2_sel, retention_en, exec_from_sram, flash_pd_req;
  logic det_en, det_fall, det_rise, reset_pin_n, below_brownout, below_detector;
  pmode_t enter_mode, mode;
  logic [7:0] cpu_clk_req_mhz, periph_clk_req, stop01_allow, stop2_allow, standby_allow;
  logic [1:0] io_pull_sel;
  logic [4:0] wakeup_pin;
  logic [2:0] periph_supply_low, mon_ok;
  logic [3:0] evt;
  regulator_ctl_t regulator;
  clock_ctl_t clocks;
  io_ctl_t io;
  logic [7:0] cpu_max_mhz, periph_max_mhz, periph_clk_en, periph_frozen, periph_pwr_off;
  logic clk_over_limit, bor_reset, det_event;
  int error_cnt = 0;
  int cmp_count = 0;
  int det_cnt = 0;
  snap_t exp_q[$];
  event seen;

  always #5 ref_clk = ~ref_clk;

  power_mode_controller dut (.ref_clk(ref_clk), .resetn(resetn), .enter_req(enter_req),
    .enter_mode(enter_mode), .vrange2_sel(vrange2_sel), .retention_en(retention_en),
    .irq_event(evt[0]), .stop_wake_event(evt[1]), .independent_watchdog_event(evt[2]), .rtc_event(evt[3]),
    .exec_from_sram(exec_from_sram), .flash_pd_req(flash_pd_req),
    .cpu_clk_req_mhz(cpu_clk_req_mhz), .pvd_en(det_en), .pvd_on_fall(det_fall),
    .pvd_on_rise(det_rise), .io_pull_sel(io_pull_sel), .periph_clk_req(periph_clk_req),
    .stop01_allow(stop01_allow), .stop2_allow(stop2_allow), .standby_allow(standby_allow),
    .reset_pin_n(reset_pin_n), .wakeup_pin(wakeup_pin), .supply_below_bor(below_brownout),
    .supply_below_pvd(below_detector), .pvm_low(periph_supply_low), .mode(mode),
    .regulator(regulator), .clocks(clocks), .io(io), .cpu_max_mhz(cpu_max_mhz),
    .periph_max_mhz(periph_max_mhz), .clk_over_limit(clk_over_limit), .bor_reset(bor_reset),
    .pvd_event(det_event), .pvm_ok(mon_ok), .periph_clk_en(periph_clk_en),
    .periph_frozen(periph_frozen), .periph_pwr_off(periph_pwr_off));

  power_far_side far (.ref_clk(ref_clk), .reset_pin_n(reset_pin_n), .wakeup_pin(wakeup_pin),
    .below_brownout(below_brownout), .below_detector(below_detector),
    .periph_supply_low(periph_supply_low), .evt(evt));

  // ------------------------------------------------------------
  // Expected outputs per mode
  // ------------------------------------------------------------
  function automatic snap_t exp_of(pmode_t m);
    snap_t s;
    logic act, lp, stp;
    logic [7:0] al;
    act = m inside {PM_RUN, PM_SLEEP, PM_LP_RUN, PM_LP_SLEEP};
    lp = m inside {PM_LP_RUN, PM_LP_SLEEP};
    stp = m inside {PM_STOP0, PM_STOP1, PM_STOP2};
    al = (m == PM_STOP2) ? stop2_allow : stp ? stop01_allow :
         (m == PM_STANDBY) ? standby_allow : 8'h00;
    s.m = m;
    s.r.main_on = m inside {PM_RUN, PM_SLEEP, PM_STOP0};
    s.r.ret_only = (m == PM_STANDBY) && retention_en;
    s.r.lp_on = lp || (m inside {PM_STOP1, PM_STOP2}) || s.r.ret_only;
    s.c.cpu_en = m inside {PM_RUN, PM_LP_RUN};
    s.c.flash_on = act && !(exec_from_sram && flash_pd_req);
    s.c.fast_osc_en = act;
    s.c.slow_clk_en = m != PM_SHUTDOWN;
    s.c.pll_allowed = m inside {PM_RUN, PM_SLEEP};
    s.c.usb_rng_en = s.c.pll_allowed;
    s.cmax = lp ? CPU_MAX_LP_MHZ : vrange2_sel ? CLK_MAX_RANGE2_MHZ : CPU_MAX_RANGE1_MHZ;
    s.pmax = lp ? PERIPH_MAX_LP_MHZ : vrange2_sel ? CLK_MAX_RANGE2_MHZ : CPU_MAX_RANGE1_MHZ;
    s.ovr = s.c.cpu_en && (cpu_clk_req_mhz > s.cmax);
    s.bor = below_brownout;
    s.en = periph_clk_req & (act ? 8'hff : al);
    s.fr = stp ? ~al : 8'h00;
    s.po = (m inside {PM_STANDBY, PM_SHUTDOWN}) ? ~al : 8'h00;
    return s;
  endfunction

  task automatic check(string what, logic [63:0] got, logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic req(pmode_t m);
    enter_mode = m;
    enter_req = 1'b1;
    @(negedge ref_clk);
    enter_req = 1'b0;
  endtask

  // Note the expectation once the outputs have settled
  task automatic look(pmode_t m);
    @(negedge ref_clk);
    exp_q.push_back(exp_of(m));
    ->seen;
  endtask

  // Output watcher and detector pulse counter
  always @(seen) begin
    snap_t got;
    got = {mode, regulator, clocks, cpu_max_mhz, periph_max_mhz, clk_over_limit, bor_reset,
           periph_clk_en, periph_frozen, periph_pwr_off};
    check("mode outputs", 64'(got), 64'(exp_q.pop_front()));
  end

  always @(posedge ref_clk) if (det_event === 1'b1) det_cnt <= det_cnt + 1;

  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    pmode_t tg[8] = '{PM_SLEEP, PM_STOP0, PM_STOP1, PM_STOP2, PM_STANDBY, PM_STANDBY,
                      PM_SHUTDOWN, PM_SHUTDOWN};
    int wk[8] = '{0, 1, 1, 1, 2, 4, 3, 5};
    void'($urandom(32'h504332d6));
    {resetn, enter_req, vrange2_sel, retention_en, exec_from_sram, flash_pd_req} = '0;
    {det_en, det_fall, det_rise} = '0;
    enter_mode = PM_RUN;
    {cpu_clk_req_mhz, periph_clk_req, stop01_allow, stop2_allow, standby_allow} = '0;
    io_pull_sel = IO_FLOAT;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    look(PM_RUN);
    // Sleep, stop, standby and shutdown from run, refused request inside each, then its wake source
    for (int i = 0; i < 8; i++) begin
      {periph_clk_req, stop01_allow, stop2_allow, standby_allow} = $urandom;
      {retention_en, vrange2_sel} = 2'($urandom);
      io_pull_sel = 2'($urandom_range(2));
      cpu_clk_req_mhz = 8'($urandom_range(100));
      look(PM_RUN);
      req(tg[i]);
      look(tg[i]);
      req(PM_STOP2);
      look(tg[i]);
      if (tg[i] inside {PM_STANDBY, PM_SHUTDOWN}) check("io", 64'(io), {61'h0, 1'b1, io_pull_sel});
      if (tg[i] == PM_SHUTDOWN) begin
        far.pulse(2);
        look(tg[i]);
      end
      if (wk[i] < 4) far.pulse(wk[i]);
      else far.pin(wk[i] == 4 ? int'($urandom_range(4)) : 5);
      look(PM_RUN);
    end
    // Low-power run and its sleep, running from SRAM with flash down
    exec_from_sram = 1'b1;
    flash_pd_req = 1'b1;
    req(PM_LP_SLEEP);
    look(PM_RUN);
    req(PM_LP_RUN);
    look(PM_LP_RUN);
    req(PM_SLEEP);
    look(PM_LP_RUN);
    req(PM_LP_SLEEP);
    look(PM_LP_SLEEP);
    far.pulse(0);
    look(PM_LP_RUN);
    req(PM_STOP1);
    look(PM_STOP1);
    far.pulse(1);
    look(PM_RUN);
    // Brownout out of stop 2
    req(PM_STOP2);
    look(PM_STOP2);
    far.supply(1'b1, 1'b0, 3'h0);
    look(PM_RUN);
    far.supply(1'b0, 1'b0, 3'h0);
    look(PM_RUN);
    // Threshold detector edges and supply monitors
    {det_en, det_fall, det_rise} = 3'b110;
    far.supply(1'b0, 1'b1, 3'h5);
    check("detector events", 64'(det_cnt), 64'h1);
    check("supply monitor", 64'(mon_ok), 64'h2);
    {det_fall, det_rise} = 2'b01;
    far.supply(1'b0, 1'b0, 3'h0);
    check("detector events", 64'(det_cnt), 64'h2);
    {det_en, det_fall} = 2'b01;
    far.supply(1'b0, 1'b1, 3'h0);
    check("detector events", 64'(det_cnt), 64'h2);
    final_report();
  end
endmodule
